// [rwspb_far_model.sv]
// Model of the pins and the RAM self-test engine on the far side of the register block.
`timescale 1ns/10ps
`default_nettype none
module rwspb_far_model (
  input  wire logic       i_clk,
  input  wire logic [3:0] i_ext,
  input  wire logic [3:0] i_out,
  input  wire logic [3:0] i_oe,
  input  wire logic       i_start,
  input  wire logic [4:0] i_fail_pat,
  output logic      [3:0] o_pin,
  output logic            o_done,
  output logic      [4:0] o_fail
);
  int cnt = 0;
  // A driven pin follows the block; an undriven one takes the outside level.
  assign o_pin = (i_oe & i_out) | (~i_oe & i_ext);
  assign o_done = (cnt == 1);
  // Results mean nothing without done, so show the inverse pattern then.
  assign o_fail = o_done ? i_fail_pat : ~i_fail_pat;
  always @(posedge i_clk)
  begin
    if (i_start)
      cnt <= 6;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
endmodule
`default_nettype wire

// [rwspb_pkg.sv]
// Constants for the read-write scratch, pin extension and RAM self-test registers.
package rwspb_pkg;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned PIN_N      = 4;
  localparam int unsigned FAIL_N     = 5;
  localparam logic [7:0] OFS_SCRATCH = 8'h00;
  localparam logic [7:0] OFS_PROTECT = 8'h01;
  localparam logic [7:0] OFS_PINIO   = 8'h05;
  localparam logic [7:0] OFS_SELFTST = 8'h0A;
  localparam logic [7:0] PROT_KEY    = 8'h95;
  localparam logic [7:0] RST_SCRATCH = 8'h00;
  localparam logic [7:0] RST_PINIO   = 8'h0F;
  localparam logic [7:0] RST_SELFTST = 8'h00;
  // Pin register: direction bits low nibble, value bits high nibble.
  localparam int unsigned PIN_DIR_LSB = 0;
  localparam int unsigned PIN_VAL_LSB = 4;
  // Self-test register: run bit 5, central unit fail bit 4, filter units 3..0.
  localparam int unsigned ST_RUN_BIT  = 5;
  localparam int unsigned ST_FAIL_LSB = 0;
endpackage

// [rwspb_regs.sv]
// Scratch, pin extension and RAM self-test registers on the host microprocessor port.
`timescale 1ns/10ps
`default_nettype none
// Function
// RULE_01: Eight-bit scratch register, host read and write, resets zero, affects nothing.
// RULE_02: Scratch writes ignored while write protection is active.
// RULE_03: Direction bit 1 makes pin input, tristated; 0 drives pin as output.
// RULE_04: Input pin: reading its value bit returns the sampled pin level.
// RULE_05: Output pin: pin is driven with the last written value bit.
// RULE_06: Pin register resets to 0x0F: all inputs, value bits zero.
// RULE_07: Host writes run bit 1 to start; run reads 1 while testing.
// RULE_08: Hardware clears run bit when the self-test completes.
// RULE_09: Host trusts fail flags only once run reads 0 after a start.
// RULE_10: Central unit fail flag is 1 on RAM error, else 0.
// RULE_11: Separate fail flag per filter unit 0 to 3, 1 on error.
// RULE_12: All five fail flags are read only to the host.
// RULE_13: Self-test register resets zero; run bit written only when unprotected.
// RULE_14: Writing 0x95 releases protection, other values arm it; armed after reset.
// RULE_15: Starting a self-test clears all five fail flags.
module rwspb_regs #(
  parameter int unsigned PIN_N  = rwspb_pkg::PIN_N,
  parameter int unsigned FAIL_N = rwspb_pkg::FAIL_N
) (
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_sys_rst,
  input  wire logic [rwspb_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic                          i_wr,
  input  wire logic                          i_rd,
  input  wire logic [rwspb_pkg::DATA_W-1:0]  i_wdata,
  output logic      [rwspb_pkg::DATA_W-1:0]  o_rdata,
  input  wire logic [PIN_N-1:0]              i_pin_in,
  output logic      [PIN_N-1:0]              o_pin_out,
  output logic      [PIN_N-1:0]              o_pin_oe,
  output logic                               o_bist_start,
  input  wire logic                          i_bist_done,
  input  wire logic [FAIL_N-1:0]             i_bist_fail
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0]        scratch;
    logic              unprot;
    logic [PIN_N-1:0]  dir;
    logic [PIN_N-1:0]  val;
    logic              run;
    logic [FAIL_N-1:0] fail;
    logic [PIN_N-1:0]  sync1;
    logic [PIN_N-1:0]  sync2;
    logic [7:0]        rdata;
    logic              start;
  } rwspb_state_t;

  rwspb_state_t st_r;
  rwspb_state_t st_nxt;
  logic [PIN_N-1:0] pin_view;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Input pins show the synchronised level, output pins the stored value.
  genvar g;
  generate
    for (g = 0; g < PIN_N; g++)
    begin : g_pin
      assign pin_view[g] = st_r.dir[g] ? st_r.sync2[g] : st_r.val[g]; // see RULE_04
    end
  endgenerate

  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.start = 1'b0;
    st_nxt.sync1 = i_pin_in;
    st_nxt.sync2 = st_r.sync1;
    if (i_wr)
    begin
      unique case (i_addr)
        rwspb_pkg::OFS_SCRATCH:
        begin
          if (st_r.unprot)
          begin
            st_nxt.scratch = i_wdata; // see RULE_01 see RULE_02
          end
        end
        rwspb_pkg::OFS_PROTECT:
        begin
          st_nxt.unprot = (i_wdata == rwspb_pkg::PROT_KEY); // see RULE_14
        end
        rwspb_pkg::OFS_PINIO:
        begin
          st_nxt.dir = i_wdata[rwspb_pkg::PIN_DIR_LSB +: PIN_N];
          st_nxt.val = i_wdata[rwspb_pkg::PIN_VAL_LSB +: PIN_N]; // see RULE_05
        end
        rwspb_pkg::OFS_SELFTST:
        begin
          // A second start while a test runs is ignored; the engine is busy.
          if (st_r.unprot && !st_r.run && i_wdata[rwspb_pkg::ST_RUN_BIT])
          begin
            st_nxt.run   = 1'b1; // see RULE_07 see RULE_13
            st_nxt.fail  = '0; // see RULE_15
            st_nxt.start = 1'b1;
          end
        end
        default:
        begin
        end
      endcase
    end
    // Completion is taken from the engine only; host writes reach the flags only to clear them at a start.
    if (st_r.run && i_bist_done)
    begin
      st_nxt.run  = 1'b0; // see RULE_08
      st_nxt.fail = i_bist_fail; // see RULE_10 see RULE_11 see RULE_12
    end
    if (i_rd)
    begin
      unique case (i_addr)
        rwspb_pkg::OFS_SCRATCH:
        begin
          st_nxt.rdata = st_r.scratch;
        end
        rwspb_pkg::OFS_PINIO:
        begin
          st_nxt.rdata = '0;
          st_nxt.rdata[rwspb_pkg::PIN_VAL_LSB +: PIN_N] = pin_view; // see RULE_04
          st_nxt.rdata[rwspb_pkg::PIN_DIR_LSB +: PIN_N] = st_r.dir;
        end
        rwspb_pkg::OFS_SELFTST:
        begin
          st_nxt.rdata = '0;
          st_nxt.rdata[rwspb_pkg::ST_RUN_BIT] = st_r.run; // see RULE_07
          st_nxt.rdata[rwspb_pkg::ST_FAIL_LSB +: FAIL_N] = st_r.fail;
        end
        default:
        begin
          // The protection register is write only, so it reads as zero like a hole.
          st_nxt.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      st_r         <= '0;
      st_r.scratch <= rwspb_pkg::RST_SCRATCH;
      st_r.dir     <= rwspb_pkg::RST_PINIO[rwspb_pkg::PIN_DIR_LSB +: PIN_N]; // see RULE_06
      st_r.val     <= rwspb_pkg::RST_PINIO[rwspb_pkg::PIN_VAL_LSB +: PIN_N];
      st_r.run     <= rwspb_pkg::RST_SELFTST[rwspb_pkg::ST_RUN_BIT]; // see RULE_13
      st_r.fail    <= rwspb_pkg::RST_SELFTST[rwspb_pkg::ST_FAIL_LSB +: FAIL_N];
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_rdata      = st_r.rdata;
  assign o_pin_oe     = ~st_r.dir; // see RULE_03
  assign o_pin_out    = st_r.val; // see RULE_05
  assign o_bist_start = st_r.start;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  sequence s_start;
    i_wr && i_addr == rwspb_pkg::OFS_SELFTST && st_r.unprot && !st_r.run
      && i_wdata[rwspb_pkg::ST_RUN_BIT];
  endsequence

  sequence s_done;
    st_r.run && i_bist_done;
  endsequence

  chk_scratch_protected: assert property ( // see RULE_02
    i_wr && i_addr == rwspb_pkg::OFS_SCRATCH && !st_r.unprot |=> $stable(st_r.scratch))
    else $error("Scratch changed while protected.");
  chk_scratch_write: assert property ( // see RULE_01
    i_wr && i_addr == rwspb_pkg::OFS_SCRATCH && st_r.unprot
      |=> st_r.scratch == $past(i_wdata))
    else $error("Scratch write lost.");
  chk_protect_key: assert property ( // see RULE_14
    i_wr && i_addr == rwspb_pkg::OFS_PROTECT
      |=> st_r.unprot == ($past(i_wdata) == rwspb_pkg::PROT_KEY))
    else $error("Protection state wrong after key write.");
  chk_pin_enable: assert property ( // see RULE_03
    o_pin_oe == ~st_r.dir && o_pin_out == st_r.val)
    else $error("Pin drive does not follow direction bits.");
  chk_pin_readback: assert property ( // see RULE_04
    i_rd && i_addr == rwspb_pkg::OFS_PINIO && st_r.dir[0]
      |=> o_rdata[rwspb_pkg::PIN_VAL_LSB] == $past(st_r.sync2[0]))
    else $error("Input pin level not returned.");
  chk_start_runs: assert property ( // see RULE_07
    s_start |=> st_r.run && o_bist_start && st_r.fail == '0 ##1 !o_bist_start)
    else $error("Self-test start not taken.");
  chk_done_clears: assert property ( // see RULE_08
    s_done |=> !st_r.run && st_r.fail == $past(i_bist_fail))
    else $error("Completion not recorded.");
  chk_run_holds: assert property ( // see RULE_07
    st_r.run && !i_bist_done |=> st_r.run)
    else $error("Run bit dropped before completion.");
  chk_fail_readonly: assert property ( // see RULE_12
    !st_r.run && !$past(st_r.run) ##1 !st_r.run |-> $stable(st_r.fail))
    else $error("Fail flags changed without a test.");
  chk_start_protected: assert property ( // see RULE_13
    !st_r.unprot && !st_r.run |=> !st_r.run)
    else $error("Self-test started while protected.");
  chk_pin_drive_write: assert property ( // see RULE_05
    i_wr && i_addr == rwspb_pkg::OFS_PINIO
      |=> o_pin_oe == ~$past(i_wdata[rwspb_pkg::PIN_DIR_LSB +: PIN_N])
        && o_pin_out == $past(i_wdata[rwspb_pkg::PIN_VAL_LSB +: PIN_N]))
    else $error("Pin drive does not follow the written register.");
  chk_pin_reset_value: assert property ( // see RULE_06
    $fell(i_sys_rst) |-> o_pin_oe == '0 && o_pin_out == '0 && !st_r.unprot)
    else $error("Pins or protection not at reset values.");
  chk_selftest_read: assert property ( // see RULE_09
    i_rd && i_addr == rwspb_pkg::OFS_SELFTST
      |=> o_rdata[rwspb_pkg::ST_RUN_BIT] == $past(st_r.run)
        && o_rdata[rwspb_pkg::ST_FAIL_LSB +: FAIL_N] == $past(st_r.fail))
    else $error("Self-test register read wrong.");

endmodule
`default_nettype wire

// [rwspb_regs_tb.sv]
// Self-checking bench for the scratch, pin and self-test registers.
`timescale 1ns/10ps
`default_nettype none
module rwspb_regs_tb;
  logic       clk = 0;
  logic       rst = 1;
  logic [7:0] addr = 8'h00;
  logic       wr = 0;
  logic       rd = 0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [7:0] got;
  logic [3:0] ext = 4'h0;
  logic [3:0] pin;
  logic [3:0] pout;
  logic [3:0] poe;
  logic       start;
  logic       done;
  logic [4:0] fail;
  logic [4:0] pat = 5'h00;
  int         bad_count = 0;
  int         samples_checked = 0;
  rwspb_regs dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_addr(addr), .i_wr(wr), .i_rd(rd),
    .i_wdata(wdata), .o_rdata(rdata), .i_pin_in(pin), .o_pin_out(pout), .o_pin_oe(poe),
    .o_bist_start(start), .i_bist_done(done), .i_bist_fail(fail));
  rwspb_far_model fm (.i_clk(clk), .i_ext(ext), .i_out(pout), .i_oe(poe), .i_start(start),
    .i_fail_pat(pat), .o_pin(pin), .o_done(done), .o_fail(fail));
  initial
  begin
    forever #2 clk = ~clk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] act);
    samples_checked++;
    if (act !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, act);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1;
    @(negedge clk);
    wr = 0;
  endtask
  // The answer stands until the next read, so sampling a cycle late is safe.
  task automatic rd_reg(input logic [7:0] a);
    @(negedge clk);
    addr = a;
    rd = 1;
    @(negedge clk);
    rd = 0;
    @(negedge clk);
    got = rdata;
  endtask
  task automatic t_protect();
    wr_reg(8'h00, 8'h5A);
    rd_reg(8'h00);
    chk("scratch locked", 8'h00, got);
    wr_reg(8'h01, 8'h95);
    wr_reg(8'h00, 8'hA5);
    rd_reg(8'h00);
    chk("scratch open", 8'hA5, got);
    rd_reg(8'h01);
    chk("protect reads zero", 8'h00, got);
    wr_reg(8'h01, 8'h00);
    wr_reg(8'h00, 8'h3C);
    rd_reg(8'h00);
    chk("scratch rearmed", 8'hA5, got);
    rd_reg(8'h02);
    chk("unmapped", 8'h00, got);
  endtask
  task automatic t_pins();
    ext = 4'hA;
    // The pin level needs two synchroniser edges before a read can see it.
    repeat (2) @(negedge clk);
    rd_reg(8'h05);
    chk("pins in", 8'hAF, got);
    wr_reg(8'h05, 8'h5C);
    chk("pin oe", 8'h03, {4'h0, poe});
    chk("pin out", 8'h05, {4'h0, pout});
    rd_reg(8'h05);
    chk("pins mixed", 8'h9C, got);
  endtask
  task automatic t_bist(input logic [4:0] p);
    int i;
    pat = p;
    wr_reg(8'h01, 8'h95);
    wr_reg(8'h0A, 8'h20);
    rd_reg(8'h0A);
    chk("run busy", 8'h20, got);
    for (i = 0; i < 20 && got[5] !== 1'b0; i++)
      rd_reg(8'h0A);
    // A run bit that never clears is a hang; stop rather than judge stale flags.
    if (got[5] !== 1'b0)
    begin
      chk("run bit", 8'h00, got & 8'h20);
      close_out();
    end
    chk("bist result", {3'b000, p}, got);
    wr_reg(8'h0A, 8'h1F);
    rd_reg(8'h0A);
    chk("flags ro", {3'b000, p}, got);
  endtask
  task automatic t_reset_mid();
    wr_reg(8'h01, 8'h95);
    wr_reg(8'h0A, 8'h20);
    rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    chk("oe mid rst", 8'h00, {4'h0, poe});
    rd_reg(8'h00);
    chk("scratch mid rst", 8'h00, got);
    rd_reg(8'h05);
    chk("pinio mid rst", 8'hAF, got);
    rd_reg(8'h0A);
    chk("selftest mid rst", 8'h00, got);
    wr_reg(8'h00, 8'h77);
    rd_reg(8'h00);
    chk("armed mid rst", 8'h00, got);
  endtask
  initial
  begin
    repeat (10) @(negedge clk);
    rst = 0;
    rd_reg(8'h00);
    chk("scratch rst", 8'h00, got);
    rd_reg(8'h05);
    chk("pinio rst", 8'h0F, got);
    rd_reg(8'h0A);
    chk("selftest rst", 8'h00, got);
    t_protect();
    t_pins();
    t_bist(5'h16);
    t_bist(5'h09);
    wr_reg(8'h01, 8'h00);
    wr_reg(8'h0A, 8'h20);
    rd_reg(8'h0A);
    chk("start locked", 8'h09, got);
    t_reset_mid();
    close_out();
  end
endmodule
`default_nettype wire
